/* File: src/mst_pkg.sv */
package mst_pkg;
  localparam int          WORD_W       = 16;
  localparam int          PTR_W        = 8;
  localparam int          STS_W        = 8;
  localparam int          DIR_BIT      = 15;
  localparam int          ID_MSB       = 14;
  localparam int          ID_LSB       = 11;
  localparam int          ADDR_MSB     = 10;
  localparam int          ADDR_LSB     = 3;
  // Bit count at which the direction and ID are complete
  localparam logic [3:0]  ID_DONE_CNT  = 4'h4;
  // Bit count at which the status byte starts on the output
  localparam logic [3:0]  STS_START    = 4'h8;
  localparam logic [3:0]  LAST_BIT     = 4'hF;
  localparam logic [3:0]  GENERAL_CALL = 4'hF;
  localparam logic [1:0]  ID_UPPER     = 2'h0;
  localparam logic        DIR_WRITE    = 1'h0;
  localparam logic [7:0]  PTR_RST      = 8'h00;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam int          LINK_PERIOD_NS = 80;
  localparam int          CLK_PERIOD_NS  = 8;
  // Each link half period must span at least two sampling clocks
  localparam int          SAMPLES_PER_HALF =
    LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_HEADER = 3'h2,
    ST_DATA   = 3'h4
  } mst_state_type;
endpackage

/* File: src/mst_bank_if.sv */
interface mst_bank_if #(
  parameter int PTR_W  = 8,
  parameter int WORD_W = 16
);
  logic              we;
  logic [PTR_W-1:0]  waddr;
  logic [WORD_W-1:0] wdata;
  logic [PTR_W-1:0]  raddr;
  logic [WORD_W-1:0] rdata;
  modport master (output we, output waddr, output wdata, output raddr,
                  input rdata);
  modport bank   (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface

/* File: src/mst_regbank.sv */
module mst_regbank #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic nrst,
  mst_bank_if.bank bus
);
  logic [mst_pkg::WORD_W-1:0] mem_reg [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << mst_pkg::PTR_W)) begin : g_depth_check
    $error("mst_regbank: DEPTH out of pointer range");
  end

  // Addresses beyond DEPTH read as zero and drop writes
  assign bus.rdata = (int'(bus.raddr) < DEPTH) ? mem_reg[bus.raddr]
                                               : '0;

  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        mem_reg[i] <= mst_pkg::REG_RST;
      end else if (bus.we && int'(bus.waddr) == i) begin
        mem_reg[i] <= bus.wdata;
      end
    end
  end
endmodule // mst_regbank

/* File: src/mst_target.sv */
// Operation
// - Deselected: ignore inputs, output high impedance
// - Sample on falling, drive on rising edge
// - Most significant bit first, both directions
// - Partial word flags frame error, leftovers dropped
// - Header: direction, ID, address, zeros, parity
// - Matching target returns status after first byte
// - Read pointer loads, advances per word
// - Reads continue while dummy words arrive
// - Parity enabled: read MSB carries parity
// - Write pointer loads, words stored sequentially
// - Stored write words advance both pointers
// - During writes output shows read-pointer register
// - Header-only read just loads read pointer
// - Direction 0 writes, 1 reads; fixed field layout
// - ID is 00 plus pins; 15 general-call write
// - Even parity per word, optional, gates writes
// - Parity error latched, faults, blocks rest of frame's writes
module mst_target #(
  parameter int DEPTH = 256
) (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      sclk,
  input  wire logic                      chip_select_n,
  input  wire logic                      sdi,
  input  wire logic                      target_id_pin0,
  input  wire logic                      target_id_pin1,
  input  wire logic                      parity_check_enable,
  input  wire logic [mst_pkg::STS_W-1:0] device_status_byte,
  input  wire logic                      fault_clear,
  output logic                           sdo,
  output logic                           sdo_oe,
  output logic                           frame_error_flag,
  output logic                           parity_error_flag,
  output logic                           fault_out_low
);
  if (mst_pkg::SAMPLES_PER_HALF < 2) begin : g_rate_check
    $error("mst_target: sampling clock too slow for the link");
  end
  mst_bank_if #(.PTR_W(mst_pkg::PTR_W), .WORD_W(mst_pkg::WORD_W)) bank ();
  mst_regbank #(.DEPTH(DEPTH)) u_bank (
    .clock (clock),
    .nrst  (nrst),
    .bus   (bank.bank)
  );

  // Two-stage synchronisers, plus one extra stage for edge detection
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       sclk_d_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg  <= 5'h02;
      sync2_reg  <= 5'h02;
      sclk_d_reg <= 1'h0;
    end else begin
      sync1_reg  <= {target_id_pin1, target_id_pin0, sdi, chip_select_n,
                     sclk};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sync2_reg[0];
    end
  end
  logic       sclk_s, cs_n_s, sdi_s;
  logic [1:0] id_pins_s;
  assign sclk_s    = sync2_reg[0];
  assign cs_n_s    = sync2_reg[1];
  assign sdi_s     = sync2_reg[2];
  assign id_pins_s = sync2_reg[4:3];

  mst_pkg::mst_state_type     state_reg, state_next;
  logic [3:0]                 cnt_reg, cnt_next;
  logic [15:0]                shift_reg, shift_next;
  logic                       dir_reg, dir_next;
  logic                       match_reg, match_next;
  logic                       blk_reg, blk_next;
  logic [7:0]                 rd_ptr_reg, rd_ptr_next;
  logic [7:0]                 wr_ptr_reg, wr_ptr_next;
  logic                       sdo_reg, sdo_next;
  logic                       oe_reg, oe_next;
  logic                       ferr_reg, ferr_next;
  logic                       perr_reg, perr_next;
  logic                       fault_reg, fault_next;
  logic                       sclk_fall, sclk_rise;
  logic [15:0]                word;
  logic                       word_done, par_bad, sts_bit;
  logic                       ferr_set, perr_set, we;
  logic [15:0]                tx_word;
  logic [3:0]                 own_id, hdr_id;
  assign sclk_fall = !cs_n_s && sclk_d_reg && !sclk_s;
  assign sclk_rise = !cs_n_s && !sclk_d_reg && sclk_s;
  assign word      = {shift_reg[14:0], sdi_s};
  assign word_done = sclk_fall && cnt_reg == mst_pkg::LAST_BIT;
  assign par_bad   = parity_check_enable && (^word);
  assign own_id    = {mst_pkg::ID_UPPER, id_pins_s};
  assign hdr_id    = {shift_reg[2:0], sdi_s};
  assign sts_bit   = device_status_byte[~cnt_reg[2:0]];
  always_comb begin
    if (state_reg == mst_pkg::ST_HEADER) begin
      tx_word = {8'h00, device_status_byte};
    end else if (parity_check_enable) begin
      tx_word = {^bank.rdata[14:0], bank.rdata[14:0]};
    end else begin
      tx_word = bank.rdata;
    end
  end

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    dir_next    = dir_reg;
    match_next  = match_reg;
    blk_next    = blk_reg;
    rd_ptr_next = rd_ptr_reg;
    wr_ptr_next = wr_ptr_reg;
    sdo_next    = sdo_reg;
    oe_next     = oe_reg;
    ferr_set    = 1'h0;
    perr_set    = 1'h0;
    we          = 1'h0;
    case (state_reg)
      mst_pkg::ST_IDLE: begin
        oe_next = 1'h0;
        if (!cs_n_s) begin
          state_next = mst_pkg::ST_HEADER;
          cnt_next   = 4'h0;
          match_next = 1'h0;
          blk_next   = 1'h0;
          dir_next   = 1'h0;
        end
      end
      mst_pkg::ST_HEADER, mst_pkg::ST_DATA: begin
        if (cs_n_s) begin
          if (state_reg == mst_pkg::ST_HEADER || cnt_reg != 4'h0) begin
            ferr_set = 1'h1;
          end
          state_next = mst_pkg::ST_IDLE;
          oe_next    = 1'h0;
        end else begin
          if (sclk_fall) begin
            shift_next = word;
            cnt_next   = cnt_reg + 4'h1;
          end
          if (sclk_fall && state_reg == mst_pkg::ST_HEADER &&
              cnt_reg == mst_pkg::ID_DONE_CNT) begin
            dir_next   = shift_reg[3];
            match_next = hdr_id == own_id ||
                         (hdr_id == mst_pkg::GENERAL_CALL &&
                          shift_reg[3] == mst_pkg::DIR_WRITE);
          end
          if (word_done && state_reg == mst_pkg::ST_HEADER) begin
            state_next = mst_pkg::ST_DATA;
            if (match_reg) begin
              if (dir_reg != mst_pkg::DIR_WRITE) begin
                rd_ptr_next = word[mst_pkg::ADDR_MSB:mst_pkg::ADDR_LSB];
              end else if (par_bad) begin
                perr_set = 1'h1;
                blk_next = 1'h1;
              end else begin
                wr_ptr_next = word[mst_pkg::ADDR_MSB:mst_pkg::ADDR_LSB];
              end
            end
          end
          if (word_done && state_reg == mst_pkg::ST_DATA && match_reg) begin
            rd_ptr_next = rd_ptr_reg + 8'h01;
            if (dir_reg == mst_pkg::DIR_WRITE) begin
              if (!blk_reg && par_bad) begin
                perr_set = 1'h1;
                blk_next = 1'h1;
              end else if (!blk_reg) begin
                we          = 1'h1;
                wr_ptr_next = wr_ptr_reg + 8'h01;
              end
            end
          end
          if (sclk_rise) begin
            sdo_next = tx_word[~cnt_reg];
            oe_next  = match_reg && (state_reg == mst_pkg::ST_DATA ||
                                     cnt_reg >= mst_pkg::STS_START);
          end
        end
      end
      default: begin
        state_next = mst_pkg::ST_IDLE;
        oe_next    = 1'h0;
      end
    endcase
  end

  // Setting an error wins over a simultaneous clear
  // latched flags
  always_comb begin
    ferr_next  = ferr_set || (ferr_reg && !fault_clear);
    perr_next  = perr_set || (perr_reg && !fault_clear);
    fault_next = !(ferr_next || perr_next);
  end

  assign bank.we    = we;
  assign bank.waddr = wr_ptr_reg;
  assign bank.wdata = word;
  assign bank.raddr = rd_ptr_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= mst_pkg::ST_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 16'h0000;
      dir_reg    <= 1'h0;
      match_reg  <= 1'h0;
      blk_reg    <= 1'h0;
      rd_ptr_reg <= mst_pkg::PTR_RST;
      wr_ptr_reg <= mst_pkg::PTR_RST;
      sdo_reg    <= 1'h0;
      oe_reg     <= 1'h0;
      ferr_reg   <= 1'h0;
      perr_reg   <= 1'h0;
      fault_reg  <= 1'h1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      dir_reg    <= dir_next;
      match_reg  <= match_next;
      blk_reg    <= blk_next;
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      sdo_reg    <= sdo_next;
      oe_reg     <= oe_next;
      ferr_reg   <= ferr_next;
      perr_reg   <= perr_next;
      fault_reg  <= fault_next;
    end
  end
  assign sdo               = sdo_reg;
  assign sdo_oe            = oe_reg;
  assign frame_error_flag  = ferr_reg;
  assign parity_error_flag = perr_reg;
  assign fault_out_low     = fault_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_HIZ_DESELECT: assert property (
    cs_n_s |=> !oe_reg) else $error("output driven while deselected");
  AST_NOMATCH_HIZ: assert property (
    !match_reg && state_reg == mst_pkg::ST_DATA |=> !oe_reg)
    else $error("non-matching target drives output");
  AST_FRAME_ERR: assert property (
    state_reg == mst_pkg::ST_DATA && cs_n_s && cnt_reg != 4'h0
    |=> ferr_reg && !fault_reg) else $error("partial word not flagged");
  AST_RD_LOAD: assert property (
    word_done && state_reg == mst_pkg::ST_HEADER && match_reg && dir_reg
    |=> rd_ptr_reg == shift_reg[mst_pkg::ADDR_MSB:mst_pkg::ADDR_LSB])
    else $error("read pointer not loaded from header");
  AST_WR_STEP: assert property (
    we |=> wr_ptr_reg == $past(wr_ptr_reg) + 8'h01 &&
           rd_ptr_reg == $past(rd_ptr_reg) + 8'h01)
    else $error("pointers not advanced after write word");
  AST_BLOCKED: assert property (
    blk_reg && state_reg == mst_pkg::ST_DATA |-> !we)
    else $error("write after parity error");
  AST_PAR_GATE: assert property (
    we |-> !parity_check_enable || !(^word))
    else $error("write with bad parity");
  AST_WORD_ONLY: assert property (
    we |-> sclk_fall && cnt_reg == mst_pkg::LAST_BIT)
    else $error("write before word complete");
  AST_STATUS_BIT: assert property (
    sclk_rise && state_reg == mst_pkg::ST_HEADER && match_reg &&
    cnt_reg >= mst_pkg::STS_START
    |=> oe_reg && sdo_reg == $past(sts_bit))
    else $error("status bit wrong");
  AST_FAULT_PIN: assert property (
    perr_set |=> !fault_reg ##1 (!fault_reg || $past(fault_clear)))
    else $error("parity error not on fault pin");
  COV_WRITE: cover property (we ##[1:300] we);
  COV_READ_HDR: cover property (state_reg == mst_pkg::ST_DATA && dir_reg &&
                                match_reg ##1 cs_n_s);
  COV_PERR: cover property (perr_set);
  COV_FERR: cover property (ferr_set);
endmodule // mst_target

/* File: tb/mst_primary.sv */
module mst_primary (
  output logic     sclk,
  output logic     chip_select_n,
  output logic     sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = mst_pkg::LINK_PERIOD_NS / 2;
  logic sdo_line;
  // No pull on the wire: undriven shows as high impedance
  assign sdo_line = sdo_oe ? sdo : 1'bz;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end
  // clock low at select edges, MSB first
  task automatic frame(input logic [63:0] tx, input int nbits,
                       output logic [63:0] rx);
    rx = '0;
    // Odd offset keeps link edges off the system clock grid
    #3;
    chip_select_n = 1'b0;
    #HALF_NS;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = tx[i];
      #HALF_NS;
      sclk = 1'b0;
      #1;
      rx = {rx[62:0], sdo_line};
      #(HALF_NS - 1);
    end
    chip_select_n = 1'b1;
    // Released data line: show the inverse, not the last bit
    sdi = ~sdi;
    #(4 * HALF_NS);
  endtask
endmodule // mst_primary

/* File: tb/multidrop_spi_target_bench.sv */
module multidrop_spi_target_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID = 4'h2;
  localparam logic [7:0] STS = 8'hA5;
  localparam int LIMIT = 40000;
  logic clock, nrst, sclk, chip_select_n, sdi, fault_clear;
  logic target_id_pin0, target_id_pin1, parity_check_enable;
  logic [mst_pkg::STS_W-1:0] device_status_byte;
  logic sdo, sdo_oe, frame_error_flag, parity_error_flag, fault_out_low;
  logic [63:0] rx;
  int   mismatches, samples_checked, cycles;

  mst_target #(.DEPTH(256)) mst_target_inst (
    .clock(clock), .nrst(nrst), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdi(sdi),
    .target_id_pin0(target_id_pin0), .target_id_pin1(target_id_pin1),
    .parity_check_enable(parity_check_enable),
    .device_status_byte(device_status_byte), .fault_clear(fault_clear),
    .sdo(sdo), .sdo_oe(sdo_oe), .frame_error_flag(frame_error_flag),
    .parity_error_flag(parity_error_flag), .fault_out_low(fault_out_low));
  mst_primary mst_primary_inst (
    .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [15:0] hdr(logic rd, logic [3:0] id,
                                      logic [7:0] a);
    logic [15:0] h;
    h = {rd, id, a, 3'b000};
    h[0] = ^h;
    return h;
  endfunction
  function automatic logic [15:0] pw(logic [15:0] w);
    return {^w[14:0], w[14:0]};
  endfunction
  task automatic xfer(input logic [63:0] tx, input int n);
    // Start on a clock edge so every link edge stays off the clock grid
    @(posedge clock);
    mst_primary_inst.frame(tx, n, rx);
  endtask
  task automatic clear_faults();
    @(posedge clock) fault_clear <= 1'b1;
    @(posedge clock) fault_clear <= 1'b0;
    repeat (2) @(posedge clock);
    check(64'({frame_error_flag, parity_error_flag}), 64'h0, "clr");
    check(64'(fault_out_low), 64'h1, "clr pin");
  endtask

  task automatic t_write_read();
    xfer(64'({hdr(1'b0, ID, 8'h10), 32'hA1B2C3D4}), 48);
    check(64'(rx[47:32]), 64'({{8{1'bz}}, STS}), "status");
    check(64'(rx[31:0]), 64'h0, "echo");
    xfer(64'({hdr(1'b1, ID, 8'h10), 32'h0}), 48);
    check(64'(rx[31:0]), 64'hA1B2C3D4, "seq read");
    $display("test write_read done");
  endtask
  task automatic t_preload();
    xfer(64'(hdr(1'b1, ID, 8'h10)), 16);
    check(64'(rx[15:0]), 64'({{8{1'bz}}, STS}), "hdr only");
    xfer(64'({hdr(1'b0, ID, 8'h20), 32'h12345678}), 48);
    check(64'(rx[31:0]), 64'hA1B2C3D4, "preload echo");
    xfer(64'({hdr(1'b1, ID, 8'h20), 32'h0}), 48);
    check(64'(rx[31:0]), 64'h12345678, "rd 20");
    $display("test preload done");
  endtask
  task automatic t_other_id();
    xfer(64'({hdr(1'b1, 4'h1, 8'h10), 16'h0}), 32);
    check(64'(rx[31:0]), 64'({32{1'bz}}), "foreign");
    xfer(64'({hdr(1'b0, 4'hF, 8'h30), 16'h5555}), 32);
    xfer(64'({hdr(1'b1, 4'hF, 8'h30), 16'h0}), 32);
    check(64'(rx[31:0]), 64'({32{1'bz}}), "gc read");
    xfer(64'({hdr(1'b1, ID, 8'h30), 16'h0}), 32);
    check(64'(rx[15:0]), 64'h5555, "gc write");
    $display("test other_id done");
  endtask
  task automatic t_parity();
    @(posedge clock) parity_check_enable <= 1'b1;
    xfer(64'({hdr(1'b1, ID, 8'h10), 16'h0}), 32);
    check(64'(rx[15:0]), 64'(pw(16'hA1B2)), "rd par");
    xfer({hdr(1'b0, ID, 8'h40), pw(16'h0F0F), pw(16'h1111) ^ 16'h8000,
          pw(16'h2222)}, 64);
    check(64'(parity_error_flag), 64'h1, "perr");
    check(64'(fault_out_low), 64'h0, "perr pin");
    xfer(64'({hdr(1'b1, ID, 8'h40), 48'h0}), 64);
    check(64'(rx[47:0]), 64'({pw(16'h0F0F), 32'h0}), "gated");
    clear_faults();
    @(posedge clock) parity_check_enable <= 1'b0;
    $display("test parity done");
  endtask
  task automatic t_frame_err();
    xfer(64'({hdr(1'b0, ID, 8'h50), 8'hFF}), 24);
    check(64'(frame_error_flag), 64'h1, "ferr");
    check(64'(fault_out_low), 64'h0, "ferr pin");
    xfer(64'({hdr(1'b1, ID, 8'h50), 16'h0}), 32);
    check(64'(rx[15:0]), 64'h0, "no partial");
    clear_faults();
    $display("test frame_err done");
  endtask

  initial begin
    nrst = 1'b0;
    fault_clear = 1'b0;
    parity_check_enable = 1'b0;
    target_id_pin0 = ID[0];
    target_id_pin1 = ID[1];
    device_status_byte = STS;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    check(64'({sdo_oe, fault_out_low}), 64'h1, "reset");
    t_write_read();
    t_preload();
    t_other_id();
    t_parity();
    t_frame_err();
    complete_run();
  end
endmodule // multidrop_spi_target_bench
